/* File: bbcc_ctrl.v */
`timescale 1ns/10ps
// Contract
// - Software selects any converter combination
// - Arms enabled per selected converter independently
// - Voltage mode targets +-15 V unless clamped
// - Current mode: negative rail only bipolar or open output
// - Reset mode tracking, minimum positive 4 V
// - Fixed clamp follows clamp level fields
// - Auto learn senses load, fixes minimum
// - Learn loads positive level, sets done
// - Positive level read only during learn
// - Learn restarts only on rewrite
// - Max positive 32 V, 26 V limited
// - Limit applies to selected channels
// - Open output targets from arms, polarity
// - Floating strap runs logic regulator
// - Reference disabled until software enables
`include "bbcc_map.vh"
module bbcc_ctrl (
	input wire clk,
	input wire arst_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q,
	input wire [15:0] dac_code,
	input wire [3:0] load_sense,
	input wire logic_regulator_strap_n,
	output reg logic_regulator_en_q,
	output wire ref_en,
	output wire [3:0] conv_en,
	output wire [3:0] pos_arm_en,
	output wire [3:0] neg_arm_en,
	output wire [3:0] max_limit_hit,
	output reg [39:0] pos_target_q,
	output reg [39:0] neg_target_q,
	output reg [39:0] pos_min_q,
	output reg [39:0] pos_max_q,
	output wire irq
);
	// ==========================================================
	// Learn sequencer states, one-hot
	localparam S_IDLE = 3'b001;
	localparam S_SENSE = 3'b010;
	localparam S_LOAD = 3'b100;

	// Clamp level code to 100 mV units
	function signed [9:0] lvl;
		input [3:0] c;
		begin
			lvl = `BBCC_V_CL_BASE + $signed({2'b00, c, 4'b0000}) / 10'sd8;
		end
	endfunction

	// Effective mode: reserved code is read as tracking
	function [1:0] eff_mode;
		input [1:0] m;
		begin
			eff_mode = (m == 2'b11) ? `BBCC_MODE_TRACK : m;
		end
	endfunction

	reg ref_en_q;
	reg [3:0] conv_sel_q;
	reg [3:0] ch_sel_q;
	reg [3:0] hsl_q;
	reg [17:0] clamp_q;
	reg [3:0] out_i_q;
	reg [3:0] out_bip_q;
	reg [3:0] out_neg_q;
	reg [3:0] out_open_q;
	reg [1:0] st_q;
	reg [1:0] mask_q;
	reg [2:0] lstate_q;
	reg [6:0] lcnt_q;
	reg [3:0] learned_q;
	reg strap_done_q;
	wire [1:0] mode;
	wire learn_set;
	wire [1:0] st_set;
	wire wr_clamp;
	wire [17:0] clamp_wv;

	assign mode = eff_mode(clamp_q[`BBCC_CLAMP_MODE_LSB +: 2]);
	assign conv_en = conv_sel_q;
	assign pos_arm_en = conv_sel_q & clamp_q[`BBCC_CLAMP_ARMP_LSB +: 4];
	assign neg_arm_en = conv_sel_q & clamp_q[`BBCC_CLAMP_ARMN_LSB +: 4];
	assign ref_en = ref_en_q;
	assign wr_clamp = reg_wr && (reg_addr == `BBCC_OFF_CLAMP);
	// Positive level keeps its value while learning is active
	assign clamp_wv = (mode == `BBCC_MODE_LEARN)
		? {reg_wdata[17:16], clamp_q[15:12], reg_wdata[11:0]}
		: reg_wdata[17:0];
	assign learn_set = (lstate_q == S_LOAD);
	assign st_set = {(|max_limit_hit), learn_set};
	assign irq = |(st_q & ~mask_q);

	// ==========================================================
	// Strap sampled once after reset release, never under reset
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			logic_regulator_en_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			logic_regulator_en_q <= logic_regulator_strap_n;
			strap_done_q <= 1'b1;
		end
	end

	// ==========================================================
	// Register writes; status set wins over write-one clear
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_en_q <= 1'b0;
			conv_sel_q <= 4'h0;
			ch_sel_q <= 4'h0;
			hsl_q <= 4'h0;
			clamp_q <= `BBCC_RST_CLAMP;
			out_i_q <= 4'h0;
			out_bip_q <= 4'h0;
			out_neg_q <= 4'h0;
			out_open_q <= 4'h0;
			st_q <= 2'b00;
			mask_q <= 2'b00;
		end else begin
			if (reg_wr && reg_addr == `BBCC_OFF_REFCFG)
				ref_en_q <= reg_wdata[`BBCC_REF_EN_BIT];
			if (reg_wr && reg_addr == `BBCC_OFF_CONVSEL)
				conv_sel_q <= reg_wdata[3:0];
			if (reg_wr && reg_addr == `BBCC_OFF_CHCFG)
				ch_sel_q <= reg_wdata[`BBCC_CH_SEL_LSB +: 4];
			// Limit bit lands only in channels chosen at write time
			if (reg_wr && reg_addr == `BBCC_OFF_ALMCODE)
				hsl_q <= (hsl_q & ~ch_sel_q)
					| ({4{reg_wdata[`BBCC_ALM_HSL_BIT]}} & ch_sel_q);
			if (reg_wr && reg_addr == `BBCC_OFF_OUTCFG) begin
				out_i_q <= reg_wdata[3:0];
				out_bip_q <= reg_wdata[7:4];
				out_neg_q <= reg_wdata[11:8];
				out_open_q <= reg_wdata[15:12];
			end
			// A write in the load cycle keeps its other fields; the learned level wins
			if (wr_clamp)
				clamp_q <= clamp_wv;
			if (learn_set)
				clamp_q[`BBCC_CLAMP_PCL_LSB +: 4] <= learned_q;
			if (reg_wr && reg_addr == `BBCC_OFF_MASK)
				mask_q <= reg_wdata[1:0];
			if (reg_wr && reg_addr == `BBCC_OFF_STATUS)
				st_q <= (st_q & ~reg_wdata[1:0]) | st_set;
			else
				st_q <= st_q | st_set;
		end
	end

	// ==========================================================
	// Learn sequence: started only by a write of the learn code
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lstate_q <= S_IDLE;
			lcnt_q <= 7'd0;
			learned_q <= `BBCC_RST_PCL;
		end else begin
			case (lstate_q)
				S_IDLE: begin
					if (wr_clamp && eff_mode(reg_wdata[17:16]) == `BBCC_MODE_LEARN) begin
						lstate_q <= S_SENSE;
						lcnt_q <= 7'd0;
					end
				end
				S_SENSE: begin
					// The sensed value is taken at the end of the settle time
					if (lcnt_q == `BBCC_LEARN_LAST) begin
						learned_q <= load_sense;
						lstate_q <= S_LOAD;
					end else begin
						lcnt_q <= lcnt_q + 7'd1;
					end
				end
				S_LOAD: begin
					lstate_q <= S_IDLE;
				end
				default: begin
					lstate_q <= S_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Read port, one cycle latency; unmapped reads as zero
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`BBCC_OFF_REFCFG: reg_rdata_q <= {31'h0000_0000, ref_en_q};
				`BBCC_OFF_CHCFG: reg_rdata_q <= {28'h000_0000, ch_sel_q};
				`BBCC_OFF_CONVSEL: reg_rdata_q <= {28'h000_0000, conv_sel_q};
				`BBCC_OFF_CLAMP: reg_rdata_q <= {14'h0000, clamp_q};
				`BBCC_OFF_STATUS: reg_rdata_q <= {30'h0000_0000, st_q};
				`BBCC_OFF_MASK: reg_rdata_q <= {30'h0000_0000, mask_q};
				`BBCC_OFF_ALMCODE: reg_rdata_q <= {25'h000_0000, |(hsl_q & ch_sel_q), 6'h00};
				`BBCC_OFF_OUTCFG: reg_rdata_q <= {16'h0000, out_open_q, out_neg_q, out_bip_q, out_i_q};
				`BBCC_OFF_LOAD: reg_rdata_q <= {24'h00_0000, learned_q, 1'b0, lstate_q};
				default: reg_rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Per-channel rail targets
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_ch
			reg signed [9:0] p_d;
			reg signed [9:0] n_d;
			reg signed [9:0] min_d;
			wire signed [9:0] max_v;
			// Limit hits are flagged, and the positive target is clamped to the limit here
			assign max_v = hsl_q[g] ? `BBCC_V_MAX_HSL : `BBCC_V_MAX_DEF;
			assign max_limit_hit[g] = pos_arm_en[g] && (p_d >= max_v);
			always @* begin
				min_d = `BBCC_V_MIN_TRACK;
				case (mode)
					`BBCC_MODE_FIXED: min_d = lvl(clamp_q[`BBCC_CLAMP_PCL_LSB + 4*0 +: 4]);
					`BBCC_MODE_LEARN: min_d = lvl(clamp_q[`BBCC_CLAMP_PCL_LSB +: 4]);
					default: min_d = `BBCC_V_MIN_TRACK;
				endcase
				if (out_i_q[g] && out_open_q[g]) begin
					if (pos_arm_en[g] && neg_arm_en[g] && !out_neg_q[g]) begin
						p_d = `BBCC_V_OC_P_BOTH;
						n_d = `BBCC_V_OC_N_BOTH;
					end else if (pos_arm_en[g] && neg_arm_en[g]) begin
						p_d = `BBCC_V_OC_P_NEG;
						n_d = `BBCC_V_OC_N_NEG;
					end else begin
						p_d = `BBCC_V_OC_P_POS;
						n_d = `BBCC_V_ZERO;
					end
				end else if (out_i_q[g]) begin
					p_d = min_d;
					n_d = out_bip_q[g] ? `BBCC_V_N15P0 : `BBCC_V_ZERO;
				end else if (mode == `BBCC_MODE_FIXED) begin
					p_d = lvl(clamp_q[`BBCC_CLAMP_PCL_LSB +: 4]);
					n_d = -lvl(clamp_q[`BBCC_CLAMP_NCL_LSB +: 4]);
				end else begin
					p_d = `BBCC_V_15P0;
					n_d = `BBCC_V_N15P0;
				end
				if (!pos_arm_en[g])
					p_d = `BBCC_V_ZERO;
				if (!neg_arm_en[g])
					n_d = `BBCC_V_ZERO;
				if (p_d > max_v)
					p_d = max_v;
			end
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					pos_target_q[10*g +: 10] <= 10'h000;
					neg_target_q[10*g +: 10] <= 10'h000;
					pos_min_q[10*g +: 10] <= 10'h000;
					pos_max_q[10*g +: 10] <= 10'h000;
				end else begin
					pos_target_q[10*g +: 10] <= p_d;
					neg_target_q[10*g +: 10] <= n_d;
					pos_min_q[10*g +: 10] <= min_d;
					pos_max_q[10*g +: 10] <= max_v;
				end
			end
		end
	endgenerate
endmodule // bbcc_ctrl

/* File: bbcc_ctrl_sva.sv */
`timescale 1ns/10ps
`include "bbcc_map.vh"
// ==========================================================
// Register-side checker
module bbcc_ctrl_sva (
	input wire clk,
	input wire arst_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire logic_regulator_en_q,
	input wire ref_en,
	input wire [3:0] conv_en,
	input wire [3:0] pos_arm_en,
	input wire [3:0] neg_arm_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// One write cycle to a given offset
	sequence s_wr(a);
		reg_wr && reg_addr == a;
	endsequence
	// Writes land one cycle later
	property p_ref_set;
		s_wr(`BBCC_OFF_REFCFG) ##0 reg_wdata[0] |=> ref_en;
	endproperty
	a_ref_set: assert property (p_ref_set) else $error("reference not enabled");
	property p_ref_clr;
		s_wr(`BBCC_OFF_REFCFG) ##0 !reg_wdata[0] |=> !ref_en;
	endproperty
	a_ref_clr: assert property (p_ref_clr) else $error("reference not disabled");
	property p_ref_hold;
		!(reg_wr && reg_addr == `BBCC_OFF_REFCFG) |=> $stable(ref_en);
	endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("reference moved unasked");
	property p_conv_sel;
		s_wr(`BBCC_OFF_CONVSEL) |=> conv_en == $past(reg_wdata[3:0]);
	endproperty
	a_conv_sel: assert property (p_conv_sel) else $error("converter select wrong");
	property p_conv_hold;
		!(reg_wr && reg_addr == `BBCC_OFF_CONVSEL) |=> $stable(conv_en);
	endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("converters moved unasked");
	// Arms only run on a selected converter
	property p_parm;
		s_wr(`BBCC_OFF_CLAMP) |=> pos_arm_en == ($past(reg_wdata[3:0]) & conv_en);
	endproperty
	a_parm: assert property (p_parm) else $error("positive arms wrong");
	property p_narm;
		s_wr(`BBCC_OFF_CLAMP) |=> neg_arm_en == ($past(reg_wdata[7:4]) & conv_en);
	endproperty
	a_narm: assert property (p_narm) else $error("negative arms wrong");
	// Strap is taken once; the regulator must not follow later pin noise
	property p_strap_hold;
		$past(arst_n, 2) && $past(arst_n) |-> $stable(logic_regulator_en_q);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("regulator moved");
endmodule // bbcc_ctrl_sva
bind bbcc_ctrl bbcc_ctrl_sva u_sva (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .logic_regulator_en_q(logic_regulator_en_q),
	.ref_en(ref_en), .conv_en(conv_en), .pos_arm_en(pos_arm_en), .neg_arm_en(neg_arm_en));

/* File: bbcc_map.vh */
`ifndef BBCC_MAP_VH
`define BBCC_MAP_VH
// ==========================================================
// Register offsets (byte address on the plain port)
`define BBCC_ADDR_W 8
`define BBCC_OFF_REFCFG 8'h02
`define BBCC_OFF_CHCFG 8'h03
`define BBCC_OFF_CONVSEL 8'h06
`define BBCC_OFF_CLAMP 8'h07
`define BBCC_OFF_STATUS 8'h0B
`define BBCC_OFF_MASK 8'h0C
`define BBCC_OFF_ALMCODE 8'h0E
`define BBCC_OFF_OUTCFG 8'h20
`define BBCC_OFF_LOAD 8'h21
// ==========================================================
// Field positions
`define BBCC_REF_EN_BIT 0
`define BBCC_CLAMP_ARMP_LSB 0
`define BBCC_CLAMP_ARMN_LSB 4
`define BBCC_CLAMP_NCL_LSB 8
`define BBCC_CLAMP_PCL_LSB 12
`define BBCC_CLAMP_MODE_LSB 16
`define BBCC_ALM_HSL_BIT 6
`define BBCC_ST_LEARN_BIT 0
`define BBCC_ST_MAXV_BIT 1
`define BBCC_CH_SEL_LSB 0
`define BBCC_OUT_IMODE_BIT 0
`define BBCC_OUT_BIPOL_BIT 1
`define BBCC_OUT_NEG_BIT 2
`define BBCC_OUT_OPEN_BIT 3
// ==========================================================
// Clamp mode codes
`define BBCC_MODE_TRACK 2'b00
`define BBCC_MODE_FIXED 2'b01
`define BBCC_MODE_LEARN 2'b10
// ==========================================================
// Reset values
`define BBCC_RST_CLAMP 18'h0_0000
`define BBCC_RST_PCL 4'h0
// ==========================================================
// Targets in 100 mV steps, signed 10-bit
`define BBCC_V_15P0 10'sd150
`define BBCC_V_N15P0 -10'sd150
`define BBCC_V_MIN_TRACK 10'sd40
`define BBCC_V_MAX_DEF 10'sd320
`define BBCC_V_MAX_HSL 10'sd260
`define BBCC_V_OC_P_BOTH 10'sd200
`define BBCC_V_OC_N_BOTH -10'sd50
`define BBCC_V_OC_P_NEG 10'sd40
`define BBCC_V_OC_N_NEG -10'sd200
`define BBCC_V_OC_P_POS 10'sd320
`define BBCC_V_ZERO 10'sd0
`define BBCC_V_CL_BASE 10'sd40
`define BBCC_V_CL_STEP 10'sd20
// ==========================================================
// Learn threshold on the DAC code and sense settle time
`define BBCC_LEARN_THR 16'h4000
`define BBCC_LEARN_NS 2000
`define BBCC_CLK_NS 40
`define BBCC_LEARN_CYC ((`BBCC_LEARN_NS + `BBCC_CLK_NS - 1) / `BBCC_CLK_NS)
// Last count of the settle time, LEARN_CYC - 1, sized for the 7-bit counter
`define BBCC_LEARN_LAST 7'h31
`endif

/* File: bbcc_tb.sv */
`timescale 1ns/10ps
`include "bbcc_map.vh"
module testbench;
	logic clk, arst_n, reg_wr, reg_rd, strap_n, reg_en, ref_en, irq;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, rdata, d;
	logic [15:0] dac_code;
	logic [3:0] load_sense, conv_en, parm, narm;
	logic [39:0] pmin, pmax, ptgt, ntgt;
	int mismatches, check_count;
	bbcc_ctrl dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .dac_code(dac_code),
		.load_sense(load_sense), .logic_regulator_strap_n(strap_n),
		.logic_regulator_en_q(reg_en), .ref_en(ref_en), .conv_en(conv_en),
		.pos_arm_en(parm), .neg_arm_en(narm), .max_limit_hit(), .pos_target_q(ptgt),
		.neg_target_q(ntgt), .pos_min_q(pmin), .pos_max_q(pmax), .irq(irq));
	// ==========================================================
	// Clock, bus tasks and compare
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// Read data appears in the cycle after the strobe and holds until the next read
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 80 && irq !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
	endtask
	function automatic logic [39:0] lanes(input logic [9:0] c0, c1, c2, c3);
		return {c3, c2, c1, c0};
	endfunction
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rd(`BBCC_OFF_CLAMP);
		chk(d, 0);
		chk(pmin, lanes(40, 40, 40, 40));
		chk(pmax, lanes(320, 320, 320, 320));
		chk(ref_en, 0);
		chk(reg_en, 1);
		rd(8'h30);
		chk(d, 0);
	endtask
	task automatic t_ref();
		wr(`BBCC_OFF_REFCFG, 32'h0000_0001);
		chk(ref_en, 1);
		wr(`BBCC_OFF_REFCFG, 32'h0000_0000);
		chk(ref_en, 0);
	endtask
	// Every converter combination, then arms gated by selection
	task automatic t_conv();
		for (int i = 0; i < 16; i++) begin
			wr(`BBCC_OFF_CONVSEL, i);
			chk(conv_en, i);
		end
		wr(`BBCC_OFF_CLAMP, 32'h0000_005F);
		chk({narm, parm}, 8'h5F);
		wr(`BBCC_OFF_CONVSEL, 32'h0000_0006);
		chk({narm, parm}, 8'h46);
	endtask
	task automatic t_hsl();
		wr(`BBCC_OFF_CHCFG, 32'h0000_0005);
		wr(`BBCC_OFF_ALMCODE, 32'h0000_0040);
		repeat (3) @(posedge clk);
		#1 chk(pmax, lanes(260, 320, 260, 320));
		wr(`BBCC_OFF_ALMCODE, 32'h0000_0000);
		repeat (3) @(posedge clk);
		#1 chk(pmax, lanes(320, 320, 320, 320));
	endtask
	task automatic t_modes();
		wr(`BBCC_OFF_CLAMP, 32'h0003_0000);
		repeat (3) @(posedge clk);
		#1 chk(pmin, lanes(40, 40, 40, 40));
		wr(`BBCC_OFF_CLAMP, 32'h0001_7300);
		rd(`BBCC_OFF_CLAMP);
		chk(d, 32'h0001_7300);
		wr(`BBCC_OFF_CLAMP, 32'h0000_0000);
	endtask
	// Rail targets: voltage, fixed clamp, current ranges, open output cases
	task automatic t_targets();
		wr(`BBCC_OFF_CONVSEL, 32'h0000_000F);
		wr(`BBCC_OFF_CLAMP, 32'h0000_00FF);
		repeat (2) @(posedge clk);
		#1 chk(ptgt, lanes(150, 150, 150, 150));
		chk(ntgt, lanes(-150, -150, -150, -150));
		wr(`BBCC_OFF_CLAMP, 32'h0001_73FF);
		repeat (2) @(posedge clk);
		#1 chk(ptgt, lanes(54, 54, 54, 54));
		chk(ntgt, lanes(-46, -46, -46, -46));
		wr(`BBCC_OFF_CLAMP, 32'h0000_00FF);
		wr(`BBCC_OFF_OUTCFG, 32'h0000_C82F);
		repeat (2) @(posedge clk);
		#1 chk(ptgt, lanes(40, 40, 200, 40));
		chk(ntgt, lanes(0, -150, -50, -200));
		wr(`BBCC_OFF_CLAMP, 32'h0000_00BF);
		repeat (2) @(posedge clk);
		#1 chk(ptgt, lanes(40, 40, 320, 40));
		chk(ntgt, lanes(0, -150, 0, -200));
		chk(irq, 1);
		rd(`BBCC_OFF_STATUS);
		chk(d, 32'h0000_0002);
		wr(`BBCC_OFF_OUTCFG, 32'h0000_0000);
		wr(`BBCC_OFF_STATUS, 32'h0000_0003);
		chk(irq, 0);
		wr(`BBCC_OFF_CLAMP, 32'h0000_0000);
	endtask
	// Learn, refused level write, restart only on rewrite, masking
	task automatic t_learn();
		wr(`BBCC_OFF_MASK, 32'h0000_0002);
		wr(`BBCC_OFF_OUTCFG, 32'h0000_0001);
		dac_code <= 16'h5000;
		load_sense <= 4'h9;
		wr(`BBCC_OFF_CLAMP, 32'h0002_00FF);
		wait_irq();
		chk(irq, 1);
		rd(`BBCC_OFF_CLAMP);
		chk(d, 32'h0002_90FF);
		wr(`BBCC_OFF_STATUS, 32'h0000_0001);
		chk(irq, 0);
		load_sense <= 4'h3;
		wr(`BBCC_OFF_CLAMP, 32'h0002_50FF);
		rd(`BBCC_OFF_CLAMP);
		chk(d, 32'h0002_90FF);
		wait_irq();
		chk(irq, 1);
		rd(`BBCC_OFF_CLAMP);
		chk(d, 32'h0002_30FF);
		wr(`BBCC_OFF_STATUS, 32'h0000_0001);
		repeat (60) @(posedge clk);
		#1 chk(irq, 0);
		wr(`BBCC_OFF_MASK, 32'h0000_0003);
		wr(`BBCC_OFF_CLAMP, 32'h0002_00FF);
		repeat (60) @(posedge clk);
		#1 chk(irq, 0);
		rd(`BBCC_OFF_STATUS);
		chk(d[0], 1);
	endtask
	// ==========================================================
	// Verdict and main sequence
	task automatic test_done();
		$display("mismatches=%0d check_count=%0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Run needs about 350 cycles; the limit is generous
	initial begin
		#200000;
		mismatches++;
		test_done();
	end
	initial begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		dac_code = 16'h0000;
		load_sense = 4'h0;
		strap_n = 1'b1;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_ref();
		t_conv();
		t_hsl();
		t_modes();
		t_targets();
		t_learn();
		test_done();
	end
endmodule // testbench
